// >>> core/gef_map.vh
// Address map, reset values and pin-function codes for the E/F/G port block.
`ifndef GEF_MAP_VH
`define GEF_MAP_VH

`define GEF_E_FUNC_ADDR   32'h56000040
`define GEF_E_DATA_ADDR   32'h56000044
`define GEF_E_PULL_ADDR   32'h56000048
`define GEF_F_FUNC_ADDR   32'h56000050
`define GEF_F_DATA_ADDR   32'h56000054
`define GEF_F_PULL_ADDR   32'h56000058
`define GEF_G_FUNC_ADDR   32'h56000060
`define GEF_G_DATA_ADDR   32'h56000064
`define GEF_G_PULL_ADDR   32'h56000068

`define GEF_E_FUNC_RST    32'h00000000
`define GEF_F_FUNC_RST    16'h0000
`define GEF_G_FUNC_RST    32'h00000000
`define GEF_E_PULL_RST    16'h0000
`define GEF_F_PULL_RST    8'h00
`define GEF_G_PULL_RST    16'hf800
`define GEF_E_DATA_RST    16'h0000
`define GEF_F_DATA_RST    8'h00
`define GEF_G_DATA_RST    16'h0000

`define GEF_CODE_INPUT    2'h0
`define GEF_CODE_OUTPUT   2'h1
`define GEF_CODE_FUNC_A   2'h2
`define GEF_CODE_FUNC_B   2'h3

// Pins whose second function (code 11) is wired; the rest are reserved.
`define GEF_E_FUNC_B_MASK 16'h0018
`define GEF_F_FUNC_B_MASK 16'h0000
`define GEF_G_FUNC_B_MASK 16'hf8fc
// Port E pins that are open-drain in plain output mode.
`define GEF_E_OPEN_DRAIN  16'hc000

`define GEF_RESP_OKAY     2'h0
`define GEF_RESP_SLVERR   2'h2

`endif

// >>> core/gef_ports.v
// General-purpose I/O ports E, F and G with an AXI4-Lite register slave.
`timescale 1ns/100ps
`include "gef_map.vh"

module gef_ports #(
  parameter E_WIDTH = 16,
  parameter F_WIDTH = 8,
  parameter G_WIDTH = 16
) (
  input  wire                 clk,
  input  wire                 rst,
  // AXI4-Lite slave.
  input  wire [31:0]          s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output wire                 s_axi_awready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output wire                 s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [31:0]          s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output wire                 s_axi_arready,
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  // Package pins.
  input  wire [E_WIDTH-1:0]   e_pin_in,
  output wire [E_WIDTH-1:0]   e_pin_out,
  output wire [E_WIDTH-1:0]   e_pin_oe,
  output wire [E_WIDTH-1:0]   e_pullup_en,
  input  wire [F_WIDTH-1:0]   f_pin_in,
  output wire [F_WIDTH-1:0]   f_pin_out,
  output wire [F_WIDTH-1:0]   f_pin_oe,
  output wire [F_WIDTH-1:0]   f_pullup_en,
  input  wire [G_WIDTH-1:0]   g_pin_in,
  output wire [G_WIDTH-1:0]   g_pin_out,
  output wire [G_WIDTH-1:0]   g_pin_oe,
  output wire [G_WIDTH-1:0]   g_pullup_en,
  // Peripheral side: code 10 (func_a) and code 11 (func_b), one bit per pin.
  input  wire [E_WIDTH-1:0]   e_func_a_out,
  input  wire [E_WIDTH-1:0]   e_func_a_oe,
  output wire [E_WIDTH-1:0]   e_func_a_in,
  input  wire [E_WIDTH-1:0]   e_func_b_out,
  input  wire [E_WIDTH-1:0]   e_func_b_oe,
  output wire [E_WIDTH-1:0]   e_func_b_in,
  output wire [F_WIDTH-1:0]   f_func_a_in,
  input  wire [G_WIDTH-1:0]   g_func_a_out,
  input  wire [G_WIDTH-1:0]   g_func_a_oe,
  output wire [G_WIDTH-1:0]   g_func_a_in,
  input  wire [G_WIDTH-1:0]   g_func_b_out,
  input  wire [G_WIDTH-1:0]   g_func_b_oe,
  output wire [G_WIDTH-1:0]   g_func_b_in
);

  reg  [31:0]  e_func_reg;
  reg  [15:0]  e_data_reg;
  reg  [15:0]  e_pull_reg;
  reg  [15:0]  f_func_reg;
  reg  [7:0]   f_data_reg;
  reg  [7:0]   f_pull_reg;
  reg  [31:0]  g_func_reg;
  reg  [15:0]  g_data_reg;
  reg  [15:0]  g_pull_reg;

  reg          aw_held_reg;
  reg  [31:0]  aw_addr_reg;
  reg          w_held_reg;
  reg  [31:0]  w_data_reg;
  reg  [3:0]   w_strb_reg;

  // Marks every pin whose 2-bit field holds the given code.
  function [15:0] code_sel;
    input [31:0] fields;
    input [1:0]  code;
    integer      i;
    begin
      code_sel = 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        code_sel[i] = (fields[2*i +: 2] == code);
      end
    end
  endfunction

  // Merges a write into an old register value under the byte strobes.
  function [31:0] strb_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer      i;
    begin
      strb_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[8*i +: 8] = new_val[8*i +: 8];
        end
      end
    end
  endfunction

  // Output enable: plain outputs, open-drain outputs drive only a low, functions follow their peripheral.
  function [15:0] pin_oe_of;
    input [15:0] out_sel;
    input [15:0] a_sel;
    input [15:0] b_sel;
    input [15:0] od;
    input [15:0] dat;
    input [15:0] a_oe;
    input [15:0] b_oe;
    begin
      pin_oe_of = (out_sel & ~od) | (out_sel & od & ~dat) | (a_sel & a_oe) | (b_sel & b_oe);
    end
  endfunction

  // Pin level: an open-drain pin in output mode never drives a high; its high comes from the pull-up.
  function [15:0] pin_out_of;
    input [15:0] out_sel;
    input [15:0] a_sel;
    input [15:0] b_sel;
    input [15:0] od;
    input [15:0] dat;
    input [15:0] a_out;
    input [15:0] b_out;
    begin
      pin_out_of = (out_sel & ~od & dat) | (a_sel & a_out) | (b_sel & b_out);
    end
  endfunction

  // Data read: output pins return the latch, every other pin the live level.
  function [15:0] data_rd;
    input [15:0] out_sel;
    input [15:0] dat;
    input [15:0] pin;
    begin
      data_rd = (out_sel & dat) | (~out_sel & pin);
    end
  endfunction

  // True when a byte address names one of the nine registers.
  function addr_hit;
    input [31:0] addr;
    begin
      if (addr == `GEF_E_FUNC_ADDR) begin
        addr_hit = 1'b1;
      end else if (addr == `GEF_E_DATA_ADDR) begin
        addr_hit = 1'b1;
      end else if (addr == `GEF_E_PULL_ADDR) begin
        addr_hit = 1'b1;
      end else if (addr == `GEF_F_FUNC_ADDR) begin
        addr_hit = 1'b1;
      end else if (addr == `GEF_F_DATA_ADDR) begin
        addr_hit = 1'b1;
      end else if (addr == `GEF_F_PULL_ADDR) begin
        addr_hit = 1'b1;
      end else if (addr == `GEF_G_FUNC_ADDR) begin
        addr_hit = 1'b1;
      end else if (addr == `GEF_G_DATA_ADDR) begin
        addr_hit = 1'b1;
      end else if (addr == `GEF_G_PULL_ADDR) begin
        addr_hit = 1'b1;
      end else begin
        addr_hit = 1'b0;
      end
    end
  endfunction

  // Per-pin mode decode.
  // A reserved code 11 is masked off here, so its pin stays an undriven input.
  wire [15:0] e_out_sel = code_sel(e_func_reg, `GEF_CODE_OUTPUT);
  wire [15:0] e_a_sel   = code_sel(e_func_reg, `GEF_CODE_FUNC_A);
  wire [15:0] e_b_sel   = code_sel(e_func_reg, `GEF_CODE_FUNC_B) & `GEF_E_FUNC_B_MASK;
  wire [15:0] f_out_sel = code_sel({16'h0000, f_func_reg}, `GEF_CODE_OUTPUT);
  wire [15:0] f_a_sel   = code_sel({16'h0000, f_func_reg}, `GEF_CODE_FUNC_A);
  wire [15:0] g_out_sel = code_sel(g_func_reg, `GEF_CODE_OUTPUT);
  wire [15:0] g_a_sel   = code_sel(g_func_reg, `GEF_CODE_FUNC_A);
  wire [15:0] g_b_sel   = code_sel(g_func_reg, `GEF_CODE_FUNC_B) & `GEF_G_FUNC_B_MASK;
  // Port F is widened to sixteen pins so the shared helpers serve every port.
  wire [15:0] f_data_x  = {8'h00, f_data_reg};
  wire [15:0] f_pin_x   = {8'h00, f_pin_in};
  wire [15:0] f_oe_x;
  wire [15:0] f_out_x;

  // Port E pins; 15/14 are open drain in output mode.
  assign e_pin_oe  = pin_oe_of(e_out_sel, e_a_sel, e_b_sel, `GEF_E_OPEN_DRAIN,
                               e_data_reg, e_func_a_oe, e_func_b_oe);
  assign e_pin_out = pin_out_of(e_out_sel, e_a_sel, e_b_sel, `GEF_E_OPEN_DRAIN,
                                e_data_reg, e_func_a_out, e_func_b_out);
  // Unselected peripheral inputs rest high so active-low selects stay idle.
  assign e_func_a_in = e_pin_in | ~e_a_sel;
  assign e_func_b_in = e_pin_in | ~e_b_sel;

  // Port F has no driven peripheral function; code 10 only feeds interrupts.
  assign f_oe_x    = pin_oe_of(f_out_sel, 16'h0000, 16'h0000, 16'h0000,
                               f_data_x, 16'h0000, 16'h0000);
  assign f_out_x   = pin_out_of(f_out_sel, 16'h0000, 16'h0000, 16'h0000,
                                f_data_x, 16'h0000, 16'h0000);
  assign f_pin_oe  = f_oe_x[7:0];
  assign f_pin_out = f_out_x[7:0];
  assign f_func_a_in = f_pin_in | ~f_a_sel[7:0];

  assign g_pin_oe  = pin_oe_of(g_out_sel, g_a_sel, g_b_sel, 16'h0000,
                               g_data_reg, g_func_a_oe, g_func_b_oe);
  assign g_pin_out = pin_out_of(g_out_sel, g_a_sel, g_b_sel, 16'h0000,
                                g_data_reg, g_func_a_out, g_func_b_out);
  assign g_func_a_in = g_pin_in | ~g_a_sel;
  assign g_func_b_in = g_pin_in | ~g_b_sel;

  // Pull-up enables are the inverse of the disable registers.
  assign e_pullup_en = ~e_pull_reg;
  assign f_pullup_en = ~f_pull_reg;
  assign g_pullup_en = ~g_pull_reg;

  // Write channel: address and data are captured in either order, then applied together.
  // Nothing more is taken while a response waits, so one write at most is in flight.
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  wire   do_write      = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  wire [31:0] wr_e_func = strb_merge(e_func_reg, w_data_reg, w_strb_reg);
  wire [31:0] wr_e_data = strb_merge({16'h0000, e_data_reg}, w_data_reg, w_strb_reg);
  wire [31:0] wr_e_pull = strb_merge({16'h0000, e_pull_reg}, w_data_reg, w_strb_reg);
  wire [31:0] wr_f_func = strb_merge({16'h0000, f_func_reg}, w_data_reg, w_strb_reg);
  wire [31:0] wr_f_data = strb_merge({24'h000000, f_data_reg}, w_data_reg, w_strb_reg);
  wire [31:0] wr_f_pull = strb_merge({24'h000000, f_pull_reg}, w_data_reg, w_strb_reg);
  wire [31:0] wr_g_func = strb_merge(g_func_reg, w_data_reg, w_strb_reg);
  wire [31:0] wr_g_data = strb_merge({16'h0000, g_data_reg}, w_data_reg, w_strb_reg);
  wire [31:0] wr_g_pull = strb_merge({16'h0000, g_pull_reg}, w_data_reg, w_strb_reg);

  wire        wr_hit = addr_hit(aw_addr_reg);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 32'h00000000;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GEF_RESP_OKAY;
    end else begin
      // Either half may come first; each waits in its holding register.
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `GEF_RESP_OKAY : `GEF_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register file. Reserved codes are stored exactly as written.
  // Bits above a register's width are dropped on write and read back as zero.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      e_func_reg <= `GEF_E_FUNC_RST;
      e_data_reg <= `GEF_E_DATA_RST;
      e_pull_reg <= `GEF_E_PULL_RST;
      f_func_reg <= `GEF_F_FUNC_RST;
      f_data_reg <= `GEF_F_DATA_RST;
      f_pull_reg <= `GEF_F_PULL_RST;
      g_func_reg <= `GEF_G_FUNC_RST;
      g_data_reg <= `GEF_G_DATA_RST;
      g_pull_reg <= `GEF_G_PULL_RST;
    end else if (do_write) begin
      if (aw_addr_reg == `GEF_E_FUNC_ADDR) begin
        e_func_reg <= wr_e_func;
      end else if (aw_addr_reg == `GEF_E_DATA_ADDR) begin
        e_data_reg <= wr_e_data[15:0];
      end else if (aw_addr_reg == `GEF_E_PULL_ADDR) begin
        e_pull_reg <= wr_e_pull[15:0];
      end else if (aw_addr_reg == `GEF_F_FUNC_ADDR) begin
        f_func_reg <= wr_f_func[15:0];
      end else if (aw_addr_reg == `GEF_F_DATA_ADDR) begin
        f_data_reg <= wr_f_data[7:0];
      end else if (aw_addr_reg == `GEF_F_PULL_ADDR) begin
        f_pull_reg <= wr_f_pull[7:0];
      end else if (aw_addr_reg == `GEF_G_FUNC_ADDR) begin
        g_func_reg <= wr_g_func;
      end else if (aw_addr_reg == `GEF_G_DATA_ADDR) begin
        g_data_reg <= wr_g_data[15:0];
      end else if (aw_addr_reg == `GEF_G_PULL_ADDR) begin
        g_pull_reg <= wr_g_pull[15:0];
      end
    end
  end

  // Read channel: one cycle from address to data.
  // A new address waits while the previous answer is still pending.
  assign s_axi_arready = ~s_axi_rvalid;

  // Pin levels are taken in the cycle the read address is accepted, with no resynchronising.
  wire [15:0] e_rd = data_rd(e_out_sel, e_data_reg, e_pin_in);
  wire [15:0] f_rd = data_rd(f_out_sel, f_data_x, f_pin_x);
  wire [15:0] g_rd = data_rd(g_out_sel, g_data_reg, g_pin_in);

  reg  [31:0] rd_next;
  reg  [1:0]  rresp_next;
  always @* begin
    rd_next    = 32'h00000000;
    rresp_next = `GEF_RESP_OKAY;
    if (s_axi_araddr == `GEF_E_FUNC_ADDR) begin
      rd_next = e_func_reg;
    end else if (s_axi_araddr == `GEF_E_DATA_ADDR) begin
      rd_next = {16'h0000, e_rd};
    end else if (s_axi_araddr == `GEF_E_PULL_ADDR) begin
      rd_next = {16'h0000, e_pull_reg};
    end else if (s_axi_araddr == `GEF_F_FUNC_ADDR) begin
      rd_next = {16'h0000, f_func_reg};
    end else if (s_axi_araddr == `GEF_F_DATA_ADDR) begin
      rd_next = {24'h000000, f_rd[7:0]};
    end else if (s_axi_araddr == `GEF_F_PULL_ADDR) begin
      rd_next = {24'h000000, f_pull_reg};
    end else if (s_axi_araddr == `GEF_G_FUNC_ADDR) begin
      rd_next = g_func_reg;
    end else if (s_axi_araddr == `GEF_G_DATA_ADDR) begin
      rd_next = {16'h0000, g_rd};
    end else if (s_axi_araddr == `GEF_G_PULL_ADDR) begin
      rd_next = {16'h0000, g_pull_reg};
    end else begin
      // An unmapped read answers zero with an error response.
      rresp_next = `GEF_RESP_SLVERR;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `GEF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_next;
      s_axi_rresp  <= rresp_next;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> sim/gef_props.sv
// Assertion checker for the E/F/G port block, bound to its top module.
`timescale 1ns/100ps
module gef_props #(
  parameter E_WIDTH = 16,
  parameter F_WIDTH = 8,
  parameter G_WIDTH = 16
) (
  input wire               clk,
  input wire               rst,
  input wire [31:0]        s_axi_araddr,
  input wire               s_axi_arvalid,
  input wire               s_axi_arready,
  input wire               s_axi_rvalid,
  input wire [31:0]        s_axi_rdata,
  input wire [1:0]         s_axi_rresp,
  input wire [E_WIDTH-1:0] e_pin_oe,
  input wire [E_WIDTH-1:0] e_pin_out,
  input wire [E_WIDTH-1:0] e_func_a_oe,
  input wire [E_WIDTH-1:0] e_func_a_out,
  input wire [E_WIDTH-1:0] e_func_b_in,
  input wire [E_WIDTH-1:0] e_pullup_en,
  input wire [F_WIDTH-1:0] f_pin_in,
  input wire [F_WIDTH-1:0] f_func_a_in,
  input wire [F_WIDTH-1:0] f_pullup_en,
  input wire [G_WIDTH-1:0] g_pin_in,
  input wire [G_WIDTH-1:0] g_func_a_in,
  input wire [G_WIDTH-1:0] g_func_b_in,
  input wire [G_WIDTH-1:0] g_pullup_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer missing");
  property p_unmapped; s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h5600004c |=> s_axi_rresp == 2'h2; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_od_high; !(|(e_pin_oe[15:14] & e_pin_out[15:14] & ~(e_func_a_oe[15:14] & e_func_a_out[15:14]))); endproperty
  a_od_high: assert property (p_od_high) else $error("open-drain pin driven high");
  property p_f_irq; !(|(f_pin_in & ~f_func_a_in)); endproperty
  a_f_irq: assert property (p_f_irq) else $error("port F interrupt line wrong");
  property p_g_irq; !(|(g_pin_in & ~g_func_a_in)); endproperty
  a_g_irq: assert property (p_g_irq) else $error("port G interrupt line wrong");
  property p_e_resv; &(e_func_b_in | 16'h0018); endproperty
  a_e_resv: assert property (p_e_resv) else $error("port E reserved input active");
  property p_g_resv; &(g_func_b_in | 16'hf8fc); endproperty
  a_g_resv: assert property (p_g_resv) else $error("port G reserved input active");
  property p_rst_pull; $fell(rst) |-> &e_pullup_en && &f_pullup_en && g_pullup_en == 16'h07ff; endproperty
  a_rst_pull: assert property (p_rst_pull) else $error("pull-up state wrong after reset");
endmodule

// >>> sim/gef_pins.sv
// Pad model: device drive wins, then an outside driver, then the pull-up.
`timescale 1ns/100ps
module gef_pins #(
  parameter W = 16
) (
  input wire          clk,
  input wire [W-1:0]  pin_out,
  input wire [W-1:0]  pin_oe,
  input wire [W-1:0]  pullup_en,
  input wire [W-1:0]  ext_val,
  input wire [W-1:0]  ext_oe,
  output wire [W-1:0] pin_in
);
  // A pad left floating changes every cycle so no stale level can pass.
  logic [W-1:0] float_reg = '0;
  always @(posedge clk) begin
    float_reg <= ~float_reg;
  end
  assign pin_in = (pin_oe & pin_out) |
                  (~pin_oe & ((ext_oe & ext_val) | (~ext_oe & (pullup_en | float_reg))));
endmodule

// >>> sim/test_gpio_ports_e_f_g.sv
// Self-checking bench for the E/F/G port block.
`timescale 1ns/100ps
`include "gef_map.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_gpio_ports_e_f_g;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [15:0]  e_pin_in, e_pin_out, e_pin_oe, e_pullup_en, e_func_a_in, e_func_b_in;
  wire [15:0]  g_pin_in, g_pin_out, g_pin_oe, g_pullup_en, g_func_a_in, g_func_b_in;
  wire [7:0]   f_pin_in, f_pin_out, f_pin_oe, f_pullup_en, f_func_a_in;
  logic [15:0] e_func_a_out = '0, e_func_a_oe = '0, e_func_b_out = '0, e_func_b_oe = '0;
  logic [15:0] g_func_a_out = '0, g_func_a_oe = '0, g_func_b_out = '0, g_func_b_oe = '0;
  logic [63:0] ext_val = '0, ext_oe = '1;
  int          errors = 0;
  int          total_checks = 0;
  gef_ports DUT (.*);
  gef_pins #(.W(16)) pins_e (.clk(clk), .pin_out(e_pin_out), .pin_oe(e_pin_oe), .pullup_en(e_pullup_en),
    .ext_val(ext_val[15:0]), .ext_oe(ext_oe[15:0]), .pin_in(e_pin_in));
  gef_pins #(.W(8)) pins_f (.clk(clk), .pin_out(f_pin_out), .pin_oe(f_pin_oe), .pullup_en(f_pullup_en),
    .ext_val(ext_val[23:16]), .ext_oe(ext_oe[23:16]), .pin_in(f_pin_in));
  gef_pins #(.W(16)) pins_g (.clk(clk), .pin_out(g_pin_out), .pin_oe(g_pin_oe), .pullup_en(g_pullup_en),
    .ext_val(ext_val[47:32]), .ext_oe(ext_oe[47:32]), .pin_in(g_pin_in));
  always #4 clk = ~clk;
  function automatic logic [15:0] wid(input int p);
    return (p == 1) ? 16'h00ff : 16'hffff;
  endfunction
  // Port p, item k: enable, level, pull-up, then oe/out/in of code 10 and of code 11.
  function automatic logic [15:0] sig(input int p, input int k);
    logic [15:0] v [3][9];
    v[0] = '{e_pin_oe, e_pin_out, e_pullup_en, e_func_a_oe, e_func_a_out, e_func_a_in, e_func_b_oe, e_func_b_out,
             e_func_b_in};
    v[1] = '{16'(f_pin_oe), 16'(f_pin_out), 16'(f_pullup_en), 16'h0, 16'h0, 16'(f_func_a_in), 16'h0, 16'h0,
             16'(f_func_a_in)};
    v[2] = '{g_pin_oe, g_pin_out, g_pullup_en, g_func_a_oe, g_func_a_out, g_func_a_in, g_func_b_oe, g_func_b_out,
             g_func_b_in};
    return v[p][k];
  endfunction
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic [1:0] r);
    logic aw, wt, ar, done;
    @(posedge clk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    do begin
      @(negedge clk);
      aw = s_axi_awvalid & s_axi_awready;
      wt = s_axi_wvalid & s_axi_wready;
      ar = s_axi_arvalid & s_axi_arready;
      done = w ? s_axi_bvalid : s_axi_rvalid;
      r = w ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!done);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic stir();
    @(posedge clk);
    e_func_a_out <= 16'($urandom);
    e_func_a_oe <= 16'($urandom);
    e_func_b_out <= 16'($urandom);
    e_func_b_oe <= 16'($urandom);
    g_func_a_out <= 16'($urandom);
    g_func_b_out <= 16'($urandom);
    g_func_b_oe <= 16'($urandom);
    ext_val <= {$urandom, $urandom};
    ext_oe <= '1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end
  initial begin : main
    logic [31:0] a, q, d, u;
    logic [15:0] s, fo, eo;
    logic [1:0]  r;
    void'($urandom(98301));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      a = `GEF_E_FUNC_ADDR + 32'h10 * p;
      bus(0, a, 0, q, r);
      `CHK("function reset", 32'h0, q)
      bus(0, a + 8, 0, q, r);
      `CHK("pull-up reset", (p == 2) ? 32'hf800 : 32'h0, q)
    end
    bus(0, 32'h5600004c, 0, q, r);
    `CHK("unmapped read", `GEF_RESP_SLVERR, r)
    `CHK("unmapped read data", 32'h0, q)
    bus(1, 32'h5600004c, 32'hffffffff, q, r);
    `CHK("unmapped write", `GEF_RESP_SLVERR, r)
    for (int i = 0; i < 12; i++) begin
      for (int p = 0; p < 3; p++) begin
        a = `GEF_E_FUNC_ADDR + 32'h10 * p;
        d = $urandom;
        s = (p == 0) ? `GEF_E_OPEN_DRAIN : 16'h0;
        bus(1, a, 32'h55555555, q, r);
        bus(1, a + 4, d, q, r);
        `CHK("write response", `GEF_RESP_OKAY, r)
        @(negedge clk);
        `CHK("pin enable", (~s | ~d[15:0]) & wid(p), sig(p, 0))
        `CHK("pin level", d[15:0] & ~s & wid(p), sig(p, 1))
        bus(0, a + 4, 0, q, r);
        `CHK("output data", d & 32'(wid(p)), q)
        `CHK("read response", `GEF_RESP_OKAY, r)
        u = $urandom;
        bus(1, a, 0, q, r);
        bus(1, a + 8, u, q, r);
        stir();
        @(posedge clk);
        ext_oe[16 * p +: 16] <= u[15:0] | 16'($urandom);
        @(negedge clk);
        `CHK("pull-up pins", ~u[15:0] & wid(p), sig(p, 2))
        eo = ext_oe[16 * p +: 16];
        bus(0, a + 4, 0, q, r);
        `CHK("input data", 32'(((eo & ext_val[16 * p +: 16]) | ~eo) & wid(p)), q)
        bus(0, a + 8, 0, q, r);
        `CHK("pull-up data", u & 32'(wid(p)), q)
        for (int c = 2; c < 4; c++) begin
          bus(1, a, (c == 2) ? 32'haaaaaaaa : 32'hffffffff, q, r);
          stir();
          @(negedge clk);
          s = (c == 2) ? wid(p) : (p == 0) ? `GEF_E_FUNC_B_MASK : (p == 1) ? `GEF_F_FUNC_B_MASK : `GEF_G_FUNC_B_MASK;
          fo = sig(p, 3 * c - 3);
          `CHK("function enable", fo & s, sig(p, 0))
          eo = (s & ((fo & sig(p, 3 * c - 2)) | (~fo & ext_val[16 * p +: 16]))) | (~s & wid(p));
          `CHK("function input", eo, sig(p, 3 * c - 1))
        end
        bus(0, a, 0, q, r);
        `CHK("reserved code kept", (p == 1) ? 32'h0000ffff : 32'hffffffff, q)
      end
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("enable after reset", 16'h0, sig(0, 0))
    `CHK("pull-up after reset", 16'h07ff, sig(2, 2))
    report_and_stop();
  end
endmodule
bind gef_ports gef_props #(.E_WIDTH(E_WIDTH), .F_WIDTH(F_WIDTH), .G_WIDTH(G_WIDTH)) u_props (.*);
